/* tb_top.sv */
// Purpose: Self-checking bench of the watchdog timer.
// Assumes: ce_i high; control clock switched through ctl_sub.
// Notes:   Inputs driven at the falling edge.
`timescale 1ns/1ps
// ====
// Bench
module tb_top;
  localparam logic [15:0] CS = 16'hFFA8;
  localparam logic [15:0] CN = 16'hFFA9;
  // Ticks in a 50-edge window at one tick per two edges
  localparam logic [9:0]  WIN  = 10'h019;
  // Settle field 7 with unit 4: (7 + 1) * 4 blocked edges, half are ticks
  localparam logic [9:0]  SETL = 10'h010;
  logic              clk_i, nrst_i, sub_tick_i, ctl_sub;
  logic [2:0]        stl;
  wdt_pkg::wdt_req_t req_i;
  logic [7:0]        rdata_o, v, d;
  logic              rvalid_o, irq, nmi, crst, reset_out_pin_n;
  logic [7:0]        q[$];
  int                n_fail, cmp_count, cyc, n_hi, n_lo, i;
  int                seed = 32'h924DF030;
  wdt_top #(.SETTLE_UNIT(16'h0004)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .req_i(req_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sub_tick_i(sub_tick_i),
    .ctl_sub_i(ctl_sub), .settle_time_field_i(stl),
    .interval_overflow_irq_o(irq), .nmi_req_o(nmi),
    .chip_rst_o(crst), .reset_out_pin_n_o(reset_out_pin_n));
  always #20 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    sub_tick_i <= 1'($random(seed));
    if (crst === 1'b1) n_hi++;
    if (reset_out_pin_n === 1'b0) n_lo++;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  // ====
  // Tasks
  task automatic test_done;
    $display("Counts: fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [15:0] d, input logic wd);
    @(negedge clk_i);
    req_i = '{wr: w, rd: ~w, word: wd, addr: a, wdata: d};
    @(negedge clk_i);
    req_i = '0;
  endtask : bus
  task automatic wr(input logic [15:0] d);
    bus(1'b1, CS, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 16'h0000, 1'b0);
    chk({1'b0, rvalid_o, rdata_o}, {2'h1, e});
  endtask : rd
  task automatic wait_on(ref logic s, input logic lv);
    for (int k = 0; k < 40 && s !== lv; k++) @(negedge clk_i);
    chk({9'h000, s}, {9'h000, lv});
  endtask : wait_on
  // ====
  // Sequence
  initial begin
    clk_i = 1'b0;
    nrst_i = 1'b0;
    sub_tick_i = 1'b0;
    ctl_sub = 1'b0;
    stl = 3'h7;
    req_i = '0;
    repeat (12) @(negedge clk_i);
    nrst_i = 1'b1;
    rd(CS, 8'h00);
    rd(CN, 8'h00);
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed)) & 8'h5F;
      wr({8'hA5, v});
      bus(1'b1, CS, {8'hA5, ~v}, 1'b0);
      wr({8'h3C, ~v});
      bus(1'b1, CN, {8'hA5, ~v}, 1'b1);
      wr({8'h5A, ~v});
      rd(CS, v);
      rd(CN, 8'h00);
      rd(16'h1234, 8'h00);
    end
    wr(16'hA527);
    for (i = 0; i < 4; i++) begin
      q.push_back(8'($random(seed)));
      wr({8'h5A, q[$]});
      wr({8'h77, ~q[$]});
      rd(CN, q.pop_front());
    end
    wr(16'hA500);
    wr(16'hA520);
    wr(16'h5AFD);
    wait_on(irq, 1'b1);
    rd(CS, 8'hA0);
    wr(16'hA520);
    rd(CS, 8'h20);
    chk({9'h000, irq}, 10'h000);
    wr(16'hA500);
    rd(CN, 8'h00);
    wr(16'hA520);
    for (i = 0; i < 2; i++) begin
      wr(16'h5A10);
      bus(1'b0, CN, 16'h0000, 1'b0);
      q.push_back(rdata_o);
      @(negedge clk_i);
    end
    chk(10'(q.pop_front() + q.pop_front()), 10'h021);
    for (i = 0; i < 3; i++) begin
      bus(1'b0, CN, 16'h0000, 1'b0);
      v = rdata_o;
      ctl_sub = (i == 1);
      repeat (48) @(negedge clk_i);
      bus(1'b0, CN, 16'h0000, 1'b0);
      d = rdata_o - v;
      if (i == 0) chk(10'(d), WIN);
      if (i == 1) chk(10'(d > 8'h18 || d < 8'h0D), 10'h000);
      if (i == 2) chk(10'(d), WIN - SETL);
    end
    wr(16'hA500);
    wr(16'hA560);
    wr(16'h5AFD);
    wait_on(nmi, 1'b1);
    chk({9'h000, reset_out_pin_n}, 10'h001);
    rd(CS, 8'hE0);
    wr(16'hA500);
    wr(16'hA568);
    wr(16'h5AFD);
    n_hi = 0;
    n_lo = 0;
    wait_on(crst, 1'b1);
    wr(16'hA500);
    repeat (600) @(negedge clk_i);
    chk(10'(n_hi), 10'h206);
    chk(10'(n_lo), 10'h084);
    test_done();
  end
endmodule : tb_top
bind wdt_top wdt_assertions u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .req_i(req_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .interval_overflow_irq_o(interval_overflow_irq_o),
  .nmi_req_o(nmi_req_o), .chip_rst_o(chip_rst_o),
  .reset_out_pin_n_o(reset_out_pin_n_o));

/* wdt_assertions.sv */
// Purpose: Port checks of the watchdog timer.
// Assumes: One clock domain; ce_i high in use.
// Notes:   Pulse lengths measured by helper counters.
`timescale 1ns/1ps
// ====
// Checker
module wdt_assertions (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              nrst_i,
  input wire logic              ce_i,
  // Bus
  input wire wdt_pkg::wdt_req_t req_i,
  input wire logic [7:0]        rdata_o,
  input wire logic              rvalid_o,
  // Requests
  input wire logic              interval_overflow_irq_o,
  input wire logic              nmi_req_o,
  input wire logic              chip_rst_o,
  input wire logic              reset_out_pin_n_o
);
  logic [9:0] hi_len_r;
  logic [9:0] lo_len_r;
  logic       csr_wr;
  assign csr_wr = ce_i && req_i.wr && req_i.word &&
                  req_i.addr == wdt_pkg::WDT_ADDR_CSR &&
                  req_i.wdata[15:8] == 8'hA5;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_len_r <= 10'h000;
      lo_len_r <= 10'h000;
    end else begin
      hi_len_r <= chip_rst_o ? hi_len_r + 10'h001 : 10'h000;
      lo_len_r <= reset_out_pin_n_o ? 10'h000 : lo_len_r + 10'h001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ====
  // Properties
  property p_rd_ans;
    ce_i && req_i.rd |=> rvalid_o;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_rd_none;
    ce_i && !req_i.rd |=> !rvalid_o;
  endproperty
  a_rd_none: assert property (p_rd_none)
    else $error("answer without read");
  property p_rd_unmap;
    ce_i && req_i.rd && req_i.addr != wdt_pkg::WDT_ADDR_CSR &&
    req_i.addr != wdt_pkg::WDT_ADDR_CNT |=> rdata_o == 8'h00;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap)
    else $error("unmapped read not zero");
  property p_nmi_pulse;
    nmi_req_o |=> !nmi_req_o;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse)
    else $error("nmi longer than one cycle");
  property p_rst_len;
    $fell(chip_rst_o) && $past(nrst_i) |-> hi_len_r == 10'h206;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("internal reset length wrong");
  property p_reset_out_pin_len;
    $rose(reset_out_pin_n_o) && $past(nrst_i) |-> lo_len_r == 10'h084;
  endproperty
  a_reset_out_pin_len: assert property (p_reset_out_pin_len)
    else $error("reset out length wrong");
  property p_together;
    $rose(chip_rst_o) |-> $fell(reset_out_pin_n_o);
  endproperty
  a_together: assert property (p_together)
    else $error("reset pulses not together");
  property p_reset_out_pin_in;
    !reset_out_pin_n_o |-> chip_rst_o;
  endproperty
  a_reset_out_pin_in: assert property (p_reset_out_pin_in)
    else $error("reset out outside reset");
  property p_wt_noirq;
    csr_wr && req_i.wdata[6] |=> !interval_overflow_irq_o;
  endproperty
  a_wt_noirq: assert property (p_wt_noirq)
    else $error("interval irq in watchdog mode");
  c_nmi: cover property (nmi_req_o);
  c_rst: cover property ($rose(chip_rst_o));
  c_irq: cover property ($rose(interval_overflow_irq_o));
endmodule : wdt_assertions

/* wdt_pkg.sv */
// Purpose: Shared constants and types of the watchdog/interval timer.
// Assumes: 8-bit registers on a 16-bit CPU bus, byte addressed.
// Notes:   Control/status field order matches the packed struct below.

// ==========================================================================
// Package
package wdt_pkg;

  // ========================================================================
  // Register map and keys
  localparam logic [15:0] WDT_ADDR_CSR = 16'hFFA8;
  localparam logic [15:0] WDT_ADDR_CNT = 16'hFFA9;
  localparam logic [7:0]  WDT_KEY_CNT  = 8'h5A;
  localparam logic [7:0]  WDT_KEY_CSR  = 8'hA5;
  localparam logic [7:0]  WDT_CSR_RST  = 8'h00;
  localparam logic [7:0]  WDT_CNT_RST  = 8'h00;
  localparam logic [7:0]  WDT_CNT_MAX  = 8'hFF;
  localparam logic [7:0]  WDT_RD_NONE  = 8'h00;

  // ========================================================================
  // Field positions
  localparam int WDT_BIT_OVF = 7;
  localparam int WDT_BIT_WT  = 6;
  localparam int WDT_BIT_RUN = 5;
  localparam int WDT_BIT_PSS = 4;
  localparam int WDT_BIT_RST = 3;

  // ========================================================================
  // Timing counts
  localparam logic [9:0] WDT_CHIP_RST_CYC = 10'h206;
  localparam logic [9:0] WDT_RESET_OUT_PIN_CYC     = 10'h084;
  localparam logic [1:0] WDT_LAG_TICKS    = 2'h2;

  // Prescaler taps: log2 of the divisor per clock select code
  localparam int WDT_MAIN_LOG2 [8] = '{1, 6, 7, 9, 11, 13, 15, 17};
  localparam int WDT_SUB_LOG2  [8] = '{1, 2, 3, 4, 5, 6, 7, 8};
  localparam int WDT_PM_W = 17;
  localparam int WDT_PS_W = 7;

  // ========================================================================
  // Types
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } wdt_req_t;

  typedef struct packed {
    logic       ovf;
    logic       wt;
    logic       run;
    logic       pss;
    logic       rst_sel;
    logic [2:0] cks;
  } wdt_csr_t;

endpackage : wdt_pkg

/* wdt_presc.sv */
// Purpose: Main and sub prescalers with clock select tap.
// Assumes: sub_tick_i is a one-cycle pulse per sub-clock period.
// Notes:   Tick output is registered.

`timescale 1ns/1ps

// ==========================================================================
// Prescaler
module wdt_presc (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       ce_i,
  // Selection
  input  wire logic       pss_i,
  input  wire logic [2:0] cks_i,
  input  wire logic       sub_tick_i,
  // Tick
  output logic            tick_o
);

  logic [wdt_pkg::WDT_PM_W-1:0] pm_r;
  logic [wdt_pkg::WDT_PM_W-1:0] pm_nxt;
  logic [wdt_pkg::WDT_PS_W-1:0] ps_r;
  logic [wdt_pkg::WDT_PS_W-1:0] ps_nxt;
  logic                         tick_r;
  logic                         tick_nxt;
  logic [7:0]                   mhit;
  logic [7:0]                   shit;

  // ========================================================================
  // Tap decode per select code
  for (genvar e = 0; e < 8; e++) begin : g_tap
    assign mhit[e] = &pm_r[wdt_pkg::WDT_MAIN_LOG2[e]-1:0];
    if (e < 7) begin : g_sub
      assign shit[e] = sub_tick_i & (&ps_r[wdt_pkg::WDT_SUB_LOG2[e]-1:0]);
    end else begin : g_main
      assign shit[e] = &pm_r[wdt_pkg::WDT_SUB_LOG2[e]-1:0];
    end
  end

  always_comb begin
    pm_nxt   = pm_r + 1'b1;
    ps_nxt   = sub_tick_i ? ps_r + 1'b1 : ps_r;
    tick_nxt = pss_i ? shit[cks_i] : mhit[cks_i];
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pm_r   <= '0;
      ps_r   <= '0;
      tick_r <= 1'b0;
    end else if (ce_i) begin
      pm_r   <= pm_nxt;
      ps_r   <= ps_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule : wdt_presc

/* wdt_rstgen.sv */
// Purpose: Internal reset and reset-out pulse stretcher.
// Assumes: start_i is a one-cycle pulse.
// Notes:   Both pulses start together; outputs are registered.

`timescale 1ns/1ps

// ==========================================================================
// Reset generator
module wdt_rstgen (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  // Trigger
  input  wire logic start_i,
  // Outputs
  output logic      chip_rst_o,
  output logic      reset_out_n_o
);

  logic [9:0] crc_r;
  logic [9:0] crc_nxt;
  logic [9:0] roc_r;
  logic [9:0] roc_nxt;
  logic       crst_r;
  logic       crst_nxt;
  logic       ron_r;
  logic       ron_nxt;

  always_comb begin
    crc_nxt = (crc_r != 10'h000) ? crc_r - 1'b1 : crc_r;
    roc_nxt = (roc_r != 10'h000) ? roc_r - 1'b1 : roc_r;
    if (start_i) begin
      crc_nxt = wdt_pkg::WDT_CHIP_RST_CYC;
      roc_nxt = wdt_pkg::WDT_RESET_OUT_PIN_CYC;
    end
    crst_nxt = (crc_nxt != 10'h000);
    ron_nxt  = (roc_nxt == 10'h000);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crc_r  <= 10'h000;
      roc_r  <= 10'h000;
      crst_r <= 1'b0;
      ron_r  <= 1'b1;
    end else if (ce_i) begin
      crc_r  <= crc_nxt;
      roc_r  <= roc_nxt;
      crst_r <= crst_nxt;
      ron_r  <= ron_nxt;
    end
  end

  assign chip_rst_o    = crst_r;
  assign reset_out_n_o = ron_r;

endmodule : wdt_rstgen

/* wdt_top.sv */
// Purpose: Watchdog / interval timer with keyed word writes.
// Assumes: One bus access per cycle; write data valid with wr.
// Notes:   Clock-switch gating is for the sub-clock-capable unit.

`timescale 1ns/1ps

// ==========================================================================
// Top
// Contract
// - Interval mode: overflow flag set raises the interval overflow irq.
// - Watchdog mode, interrupt option: overflow requests a non-maskable irq.
// - Counter and control accept only word writes; byte writes do nothing.
// - Shared address, upper byte counter key: low byte loads the counter.
// - Shared address, upper byte control key: low byte loads control.
// - Reads: control at the first byte address, counter at the next.
// - Counter write and increment in the same cycle: write wins.
// - Main to sub clock switch delays increments by about two ticks.
// - Sub to main switch blocks increments for the settle interval.
// - No clock switch means no counting deviation.
// - Watchdog reset option: chip reset 518 clocks, reset-out low 132.
// - Clearing run stops and zeroes the counter; setting run counts.
module wdt_top #(
  parameter bit          SWITCH_GATE = 1'b1,
  parameter logic [15:0] SETTLE_UNIT = 16'h0400
) (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  input  wire logic            ce_i,
  // CPU bus
  input  wire wdt_pkg::wdt_req_t req_i,
  output logic [7:0]           rdata_o,
  output logic                 rvalid_o,
  // Clock source control
  input  wire logic            sub_tick_i,
  input  wire logic            ctl_sub_i,
  input  wire logic [2:0]      settle_time_field_i,
  // Requests
  output logic                 interval_overflow_irq_o,
  output logic                 nmi_req_o,
  output logic                 chip_rst_o,
  output logic                 reset_out_pin_n_o
);

  // ========================================================================
  // Declarations
  wdt_pkg::wdt_csr_t csr_r;
  wdt_pkg::wdt_csr_t csr_nxt;
  wdt_pkg::wdt_csr_t csr_wr;
  logic [7:0]        cnt_r;
  logic [7:0]        cnt_nxt;
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;
  logic              rvalid_r;
  logic              rvalid_nxt;
  logic              ovf_seen_r;
  logic              ovf_seen_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic              nmi_r;
  logic              nmi_nxt;
  logic              rst_start_r;
  logic              rst_start_nxt;
  logic [1:0]        lag_r;
  logic [1:0]        lag_nxt;
  logic [15:0]       settle_r;
  logic [15:0]       settle_nxt;
  logic              ctl_q_r;
  logic              ctl_q_nxt;
  logic [31:0]       settle_prod;
  logic              presc_tick;
  logic              gated_tick;
  logic              key_hit;
  logic              wr_cnt;
  logic              wr_csr;
  logic              ovf_ev;

  // ========================================================================
  // Prescaler
  wdt_presc u_presc (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .ce_i       (ce_i),
    .pss_i      (csr_r.pss),
    .cks_i      (csr_r.cks),
    .sub_tick_i (sub_tick_i),
    .tick_o     (presc_tick)
  );

  // ========================================================================
  // Clock switch gating
  always_comb begin
    settle_prod = ({29'h0, settle_time_field_i} + 32'h1) * {16'h0, SETTLE_UNIT};
    ctl_q_nxt   = ctl_sub_i;
    lag_nxt     = lag_r;
    settle_nxt  = settle_r;
    if (lag_r != 2'h0 && sub_tick_i) begin
      lag_nxt = lag_r - 1'b1;
    end
    if (settle_r != 16'h0000) begin
      settle_nxt = settle_r - 1'b1;
    end
    if (SWITCH_GATE && ctl_sub_i && !ctl_q_r) begin
      lag_nxt    = wdt_pkg::WDT_LAG_TICKS;
      settle_nxt = 16'h0000;
    end
    if (SWITCH_GATE && !ctl_sub_i && ctl_q_r) begin
      settle_nxt = settle_prod[15:0];
      lag_nxt    = 2'h0;
    end
  end

  // Ticks pass unchanged while the clock mode stays put
  assign gated_tick = presc_tick && (lag_r == 2'h0)
                      && (settle_r == 16'h0000);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lag_r    <= 2'h0;
      settle_r <= 16'h0000;
      ctl_q_r  <= 1'b0;
    end else if (ce_i) begin
      lag_r    <= lag_nxt;
      settle_r <= settle_nxt;
      ctl_q_r  <= ctl_q_nxt;
    end
  end

  // ========================================================================
  // Write decode
  always_comb begin
    key_hit = req_i.wr && req_i.word
              && (req_i.addr == wdt_pkg::WDT_ADDR_CSR);
    wr_cnt  = key_hit
              && (req_i.wdata[15:8] == wdt_pkg::WDT_KEY_CNT);
    wr_csr  = key_hit
              && (req_i.wdata[15:8] == wdt_pkg::WDT_KEY_CSR);
    csr_wr  = wdt_pkg::wdt_csr_t'(req_i.wdata[7:0]);
  end

  // ========================================================================
  // Counter and control/status
  always_comb begin
    csr_nxt      = csr_r;
    cnt_nxt      = cnt_r;
    ovf_ev       = 1'b0;
    ovf_seen_nxt = ovf_seen_r;
    // Flag cleared by writing 0, only after it was read as 1
    if (wr_csr) begin
      csr_nxt     = csr_wr;
      csr_nxt.ovf = csr_r.ovf & (csr_wr.ovf | ~ovf_seen_r);
      if (!csr_wr.ovf && ovf_seen_r) begin
        ovf_seen_nxt = 1'b0;
      end
    end
    if (req_i.rd && req_i.addr == wdt_pkg::WDT_ADDR_CSR && csr_r.ovf) begin
      ovf_seen_nxt = 1'b1;
    end
    if (wr_cnt) begin
      cnt_nxt = req_i.wdata[7:0];
    end else if (csr_r.run && gated_tick) begin
      cnt_nxt = cnt_r + 1'b1;
      ovf_ev  = (cnt_r == wdt_pkg::WDT_CNT_MAX);
    end
    // Set wins over a simultaneous clear
    if (ovf_ev) begin
      csr_nxt.ovf = 1'b1;
    end
    if (!csr_nxt.run) begin
      cnt_nxt = wdt_pkg::WDT_CNT_RST;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      csr_r      <= wdt_pkg::wdt_csr_t'(wdt_pkg::WDT_CSR_RST);
      cnt_r      <= wdt_pkg::WDT_CNT_RST;
      ovf_seen_r <= 1'b0;
    end else if (ce_i) begin
      csr_r      <= csr_nxt;
      cnt_r      <= cnt_nxt;
      ovf_seen_r <= ovf_seen_nxt;
    end
  end

  // ========================================================================
  // Overflow requests
  always_comb begin
    irq_nxt       = csr_nxt.ovf && !csr_nxt.wt;
    nmi_nxt       = ovf_ev && csr_r.wt && !csr_r.rst_sel;
    rst_start_nxt = ovf_ev && csr_r.wt && csr_r.rst_sel;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_r       <= 1'b0;
      nmi_r       <= 1'b0;
      rst_start_r <= 1'b0;
    end else if (ce_i) begin
      irq_r       <= irq_nxt;
      nmi_r       <= nmi_nxt;
      rst_start_r <= rst_start_nxt;
    end
  end

  wdt_rstgen u_rstgen (
    .clk_i         (clk_i),
    .nrst_i        (nrst_i),
    .ce_i          (ce_i),
    .start_i       (rst_start_r),
    .chip_rst_o    (chip_rst_o),
    .reset_out_n_o (reset_out_pin_n_o)
  );

  // ========================================================================
  // Read path
  always_comb begin
    rvalid_nxt = req_i.rd;
    rdata_nxt  = rdata_r;
    if (req_i.rd) begin
      case (req_i.addr)
        wdt_pkg::WDT_ADDR_CSR: rdata_nxt = csr_r;
        wdt_pkg::WDT_ADDR_CNT: rdata_nxt = cnt_r;
        default:               rdata_nxt = wdt_pkg::WDT_RD_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r  <= wdt_pkg::WDT_RD_NONE;
      rvalid_r <= 1'b0;
    end else if (ce_i) begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign rdata_o                 = rdata_r;
  assign rvalid_o                = rvalid_r;
  assign interval_overflow_irq_o = irq_r;
  assign nmi_req_o               = nmi_r;

endmodule : wdt_top
